/* File: hw/fbd_top.sv */
// Bus operation decoder of a parallel NOR flash, with write capture
// buffer and program/erase protection gating.
// Assumes every pin is synchronous to clk_sys; the flash clock pin is
// sampled as a level and its rising edges are detected here.
//
// Overview of operation
// - A low write-protect pin puts the lock-down mechanism in force.
// - An unlock aimed at a locked-down block is rejected while lock-down is in force.
// - A high write-protect pin ignores lock-down so unlocks and changes may proceed.
// - Erase or program is refused while the program supply is at its lockout level.
// - Erase or program is also refused while the core supply is at its lockout level; bus writes are still captured.
// - Reads happen only with chip select low and the reset pin high.
// - The accessed block is decoded from the upper address bits.
// - Address latches are transparent while the address strobe and chip select are low and the reset pin is high.
// - Output enable low during a read drives the selected word onto the data bus.
// - An asynchronous read drives data out and holds wait deasserted, ignoring the clock.
// - A synchronous read drives wait actively and outputs data.
// - A write takes the data bus as input and floats wait.
// - Data bus and wait float on output disable, standby or reset.
// - Address and data of a write are captured on the rising write strobe.
// - Wait polarity comes from config bit 10; asserted means data invalid.
// - A synchronous read latches address on strobe rise or the first clock edge with strobe low.
// - Leaving reset enters asynchronous read; a low reset inhibits writes.
module fbd_top #(
    parameter int BUF_DEPTH = fbd_pkg::BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic address_latch_n,
    input wire logic flash_clk,
    input wire logic [fbd_pkg::ADDR_W-1:0] addr,
    input wire logic [fbd_pkg::DATA_W-1:0] dq_in,
    output logic [fbd_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic wait_out,
    output logic wait_oe_n,
    input wire logic [fbd_pkg::RC_W-1:0] read_config,
    input wire logic config_load,
    input wire logic [fbd_pkg::DATA_W-1:0] read_data,
    input wire logic read_valid,
    output logic [fbd_pkg::ADDR_W-1:0] array_addr,
    output logic [fbd_pkg::BLK_W-1:0] block_sel,
    output logic sync_mode,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [fbd_pkg::ADDR_W-1:0] wr_addr,
    output logic [fbd_pkg::DATA_W-1:0] wr_data,
    output logic buf_full,
    input wire logic write_protect_n,
    input wire logic program_lockout_level,
    input wire logic core_lockout_level,
    input wire logic blk_lockdown,
    input wire logic blk_locked,
    input wire logic unlock_req,
    output logic unlock_grant,
    output logic unlock_reject,
    input wire logic modify_req,
    output logic modify_grant,
    output logic modify_refuse,
    output logic lockdown_active
);
    import fbd_pkg::*;

    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);

    if (BUF_DEPTH < 2) begin : g_chk
        $error("BUF_DEPTH must be at least 2");
    end

    fbd_op_t op;
    logic clk_prev_reg;
    logic we_prev_reg;
    logic clk_rise;
    logic we_rise;

    // Operation decode from the control pins
    always_comb begin
        if (!reset_n) begin
            op = OP_RESET;
        end else if (chip_sel_n) begin
            op = OP_STANDBY;
        end else if (!write_n && out_en_n) begin
            op = OP_WRITE;
        end else if (!out_en_n && write_n) begin
            op = sync_mode ? OP_SYNC : OP_ASYNC;
        end else begin
            // Both strobes low is not a legal cycle; stay off the bus
            op = OP_DISABLE;
        end
    end

    assign clk_rise = flash_clk && !clk_prev_reg;
    assign we_rise = write_n && !we_prev_reg;

    // Read mode, address latch and bus drivers
    logic sync_mode_next;
    logic sync_latched_reg;
    logic sync_latched_next;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] dq_out_next;
    logic dq_oe_n_next;
    logic wait_out_next;
    logic wait_oe_n_next;
    logic wait_asserted;
    logic pol_reg;
    logic pol_next;

    always_comb begin
        sync_mode_next = sync_mode;
        pol_next = pol_reg;
        if (!reset_n) begin
            sync_mode_next = 1'b0;
        end else if (config_load) begin
            sync_mode_next = !read_config[RC_SYNC_BIT];
            pol_next = read_config[RC_POL_BIT];
        end
        addr_next = array_addr;
        sync_latched_next = sync_latched_reg;
        // A low reset pin also drops a clock latch left by a burst
        if (address_latch_n || chip_sel_n || !reset_n) begin
            // Strobe rise keeps the last flowed address
            sync_latched_next = 1'b0;
        end else if (!sync_latched_reg) begin
            addr_next = addr;
            if (op == OP_SYNC && clk_rise) begin
                sync_latched_next = 1'b1;
            end
        end
        wait_asserted = (op == OP_SYNC) && !read_valid;
        wait_out_next = wait_asserted ? pol_reg : !pol_reg;
        dq_out_next = dq_out;
        dq_oe_n_next = 1'b1;
        wait_oe_n_next = 1'b1;
        if (op == OP_ASYNC || op == OP_SYNC) begin
            dq_oe_n_next = 1'b0;
            wait_oe_n_next = 1'b0;
            if (op == OP_ASYNC || read_valid) begin
                dq_out_next = read_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // High start gives no false rise whichever level the pin idles at
            clk_prev_reg <= 1'b1;
            we_prev_reg <= 1'b1;
            sync_mode <= 1'b0;
            pol_reg <= POL_RESET;
            sync_latched_reg <= 1'b0;
            array_addr <= ADDR_RESET;
            block_sel <= ADDR_RESET[ADDR_W-1:BLK_LSB];
            dq_out <= DQ_RESET;
            dq_oe_n <= 1'b1;
            wait_out <= !POL_RESET;
            wait_oe_n <= 1'b1;
        end else begin
            clk_prev_reg <= flash_clk;
            we_prev_reg <= write_n;
            sync_mode <= sync_mode_next;
            pol_reg <= pol_next;
            sync_latched_reg <= sync_latched_next;
            array_addr <= addr_next;
            block_sel <= addr_next[ADDR_W-1:BLK_LSB];
            dq_out <= dq_out_next;
            dq_oe_n <= dq_oe_n_next;
            wait_out <= wait_out_next;
            wait_oe_n <= wait_oe_n_next;
        end
    end

    // Write capture buffer, head always in entry 0 so outputs are flops
    logic push;
    logic pop;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] cnt_pop;
    logic [ADDR_W-1:0] ent_a_reg [BUF_DEPTH];
    logic [DATA_W-1:0] ent_d_reg [BUF_DEPTH];
    logic [ADDR_W-1:0] ent_a_next [BUF_DEPTH];
    logic [DATA_W-1:0] ent_d_next [BUF_DEPTH];

    // Capture only with chip select low, output enable high, reset high
    assign push = we_rise && !chip_sel_n && out_en_n && reset_n && !buf_full;
    assign pop = wr_valid && wr_ready;
    assign cnt_pop = pop ? cnt_reg - CNT_ONE : cnt_reg;
    assign cnt_next = push ? cnt_pop + CNT_ONE : cnt_pop;

    for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_ent
        logic [ADDR_W-1:0] up_a;
        logic [DATA_W-1:0] up_d;
        if (i == BUF_DEPTH - 1) begin : g_last
            assign up_a = ADDR_RESET;
            assign up_d = DQ_RESET;
        end else begin : g_mid
            assign up_a = ent_a_reg[i+1];
            assign up_d = ent_d_reg[i+1];
        end
        always_comb begin
            if (push && cnt_pop == CNT_W'(i)) begin
                ent_a_next[i] = addr_next;
                ent_d_next[i] = dq_in;
            end else if (pop) begin
                ent_a_next[i] = up_a;
                ent_d_next[i] = up_d;
            end else begin
                ent_a_next[i] = ent_a_reg[i];
                ent_d_next[i] = ent_d_reg[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            wr_valid <= 1'b0;
            buf_full <= 1'b0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                ent_a_reg[i] <= ADDR_RESET;
                ent_d_reg[i] <= DQ_RESET;
            end
        end else begin
            cnt_reg <= cnt_next;
            wr_valid <= cnt_next != '0;
            buf_full <= cnt_next == CNT_FULL;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                ent_a_reg[i] <= ent_a_next[i];
                ent_d_reg[i] <= ent_d_next[i];
            end
        end
    end

    assign wr_addr = ent_a_reg[0];
    assign wr_data = ent_d_reg[0];

    // Protection gating
    logic ld_enforced;
    logic unlock_grant_next;
    logic unlock_reject_next;
    logic modify_grant_next;
    logic modify_refuse_next;
    logic supply_bad;

    always_comb begin
        ld_enforced = !write_protect_n;
        // High write-protect drops lock-down from the decision
        unlock_reject_next = unlock_req && blk_lockdown && ld_enforced;
        unlock_grant_next = unlock_req && !(blk_lockdown && ld_enforced);
        supply_bad = program_lockout_level || core_lockout_level;
        // Reset low also blocks changes; no supply check can be skipped
        modify_grant_next = modify_req && !supply_bad && !blk_locked && reset_n;
        modify_refuse_next = modify_req && !modify_grant_next;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lockdown_active <= 1'b0;
            unlock_grant <= 1'b0;
            unlock_reject <= 1'b0;
            modify_grant <= 1'b0;
            modify_refuse <= 1'b0;
        end else begin
            lockdown_active <= ld_enforced;
            unlock_grant <= unlock_grant_next;
            unlock_reject <= unlock_reject_next;
            modify_grant <= modify_grant_next;
            modify_refuse <= modify_refuse_next;
        end
    end

    // Block field of the raw address pins, for the decode check
    logic [BLK_W-1:0] addr_blk;
    assign addr_blk = addr[ADDR_W-1:BLK_LSB];

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_lockdown_follows: assert property (!write_protect_n |=> lockdown_active)
        else $error("lock-down not in force with write-protect low");
    a_unlock_rejected: assert property (unlock_req && blk_lockdown && !write_protect_n
        |=> unlock_reject && !unlock_grant)
        else $error("unlock of locked-down block not rejected");
    a_unlock_wp_high: assert property (unlock_req && write_protect_n |=> unlock_grant && !unlock_reject)
        else $error("unlock refused with write-protect high");
    a_prog_lockout: assert property (program_lockout_level |=> !modify_grant)
        else $error("modify granted at program supply lockout");
    a_core_lockout: assert property (modify_req && core_lockout_level |=> modify_refuse && !modify_grant)
        else $error("modify not refused at core supply lockout");
    a_read_gate: assert property (!dq_oe_n |-> !$past(chip_sel_n) && $past(reset_n) && !$past(out_en_n))
        else $error("data driven outside a read");
    a_block_decode: assert property (!address_latch_n && !chip_sel_n && !sync_mode && reset_n
        |=> block_sel == $past(addr_blk))
        else $error("block select does not match address");
    a_addr_flow: assert property (!address_latch_n && !chip_sel_n && !sync_mode && reset_n
        |=> array_addr == $past(addr))
        else $error("address latch not transparent");
    a_async_read: assert property (reset_n && !chip_sel_n && !out_en_n && write_n && !sync_mode
        |=> !dq_oe_n && !wait_oe_n && wait_out == !$past(pol_reg) && dq_out == $past(read_data))
        else $error("asynchronous read drive wrong");
    a_sync_wait: assert property (reset_n && !chip_sel_n && !out_en_n && write_n && sync_mode
        |=> !wait_oe_n && wait_out == ($past(read_valid) ? !$past(pol_reg) : $past(pol_reg)))
        else $error("synchronous wait level wrong");
    a_write_float: assert property (reset_n && !chip_sel_n && !write_n && out_en_n
        |=> dq_oe_n && wait_oe_n)
        else $error("bus driven during write");
    a_float_idle: assert property (chip_sel_n || !reset_n || (out_en_n && write_n)
        |=> dq_oe_n && wait_oe_n)
        else $error("bus not floated when idle");
    a_write_capture: assert property (push && cnt_reg == '0 && !pop
        |=> wr_valid && wr_data == $past(dq_in))
        else $error("write not captured on strobe rise");
    a_sync_latch: assert property (op == OP_SYNC && clk_rise && !address_latch_n && !sync_latched_reg
        ##1 !address_latch_n && !chip_sel_n |=> array_addr == $past(array_addr))
        else $error("synchronous address not held after clock latch");
    a_reset_async: assert property (!reset_n |=> !sync_mode ##0 dq_oe_n)
        else $error("reset did not return to asynchronous read");

    c_async_read: cover property (op == OP_ASYNC ##1 !dq_oe_n);
    c_sync_burst: cover property (op == OP_SYNC && !read_valid ##1 op == OP_SYNC && read_valid);
    c_buf_full: cover property (buf_full && !wr_ready);
    c_unlock_reject: cover property (unlock_reject);
endmodule : fbd_top

/* File: common/fbd_pkg.sv */
// Constants and types shared by the flash bus operation decoder.
// Assumes a single 10 MHz system clock samples every pin.
package fbd_pkg;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    // Upper address bits that pick the block
    localparam int BLK_LSB = 16;
    localparam int BLK_W = ADDR_W - BLK_LSB;
    localparam int RC_W = 16;
    // Read configuration fields
    localparam int RC_POL_BIT = 10;
    localparam int RC_SYNC_BIT = 15;
    // Depth of the write capture buffer
    localparam int BUF_DEPTH = 2;
    localparam logic [DATA_W-1:0] DQ_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 23'h000000;
    localparam logic POL_RESET = 1'h1;

    typedef enum logic [2:0] {
        OP_RESET,
        OP_STANDBY,
        OP_DISABLE,
        OP_ASYNC,
        OP_SYNC,
        OP_WRITE
    } fbd_op_t;
endpackage : fbd_pkg

/* File: bench/fbd_array_model.sv */
// Model of the array and the write sink on the decoder's internal side.
// Assumes the bench steers the sink stall and the late-data control.
module fbd_array_model (
    input wire logic [fbd_pkg::ADDR_W-1:0] array_addr,
    input wire logic hold_ready,
    input wire logic data_late,
    output logic [fbd_pkg::DATA_W-1:0] read_data,
    output logic read_valid,
    output logic wr_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    import fbd_pkg::*;
    // Word tied to address; not-ready data is inverted so a stale capture shows
    assign read_data = data_late ? ~(array_addr[DATA_W-1:0] ^ 16'hA5C3) : (array_addr[DATA_W-1:0] ^ 16'hA5C3);
    // Late data keeps wait asserted during burst reads
    assign read_valid = !data_late;
    // A stalled sink must not lose buffered words
    assign wr_ready = !hold_ready;
endmodule : fbd_array_model

/* File: bench/fbd_top_tb.sv */
// Self-checking bench for the flash bus operation decoder.
// Assumes pins are driven synchronously to clk_sys at 10 MHz.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module fbd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fbd_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst, reset_n, chip_sel_n, out_en_n, write_n, address_latch_n, flash_clk, config_load;
    logic read_valid, wr_ready, write_protect_n, program_lockout_level, core_lockout_level;
    logic blk_lockdown, blk_locked, unlock_req, modify_req, hold_ready, data_late;
    logic dq_oe_n, wait_out, wait_oe_n, sync_mode, wr_valid, buf_full, lockdown_active;
    logic unlock_grant, unlock_reject, modify_grant, modify_refuse;
    logic [ADDR_W-1:0] addr, array_addr, wr_addr;
    logic [DATA_W-1:0] dq_in, dq_out, read_data, wr_data;
    logic [RC_W-1:0] read_config;
    logic [BLK_W-1:0] block_sel;
    int num_errors = 0;
    int checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    fbd_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_n(reset_n), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_n(write_n), .address_latch_n(address_latch_n), .flash_clk(flash_clk),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out),
        .wait_oe_n(wait_oe_n), .read_config(read_config), .config_load(config_load), .read_data(read_data),
        .read_valid(read_valid), .array_addr(array_addr), .block_sel(block_sel), .sync_mode(sync_mode),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .buf_full(buf_full),
        .write_protect_n(write_protect_n), .program_lockout_level(program_lockout_level),
        .core_lockout_level(core_lockout_level), .blk_lockdown(blk_lockdown), .blk_locked(blk_locked),
        .unlock_req(unlock_req), .unlock_grant(unlock_grant), .unlock_reject(unlock_reject),
        .modify_req(modify_req), .modify_grant(modify_grant), .modify_refuse(modify_refuse),
        .lockdown_active(lockdown_active));

    fbd_array_model model (.array_addr(array_addr), .hold_ready(hold_ready), .data_late(data_late),
        .read_data(read_data), .read_valid(read_valid), .wr_ready(wr_ready));

    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return a[DATA_W-1:0] ^ 16'hA5C3;
    endfunction : pat

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // Checks happen mid-cycle so registered outputs have settled
    task automatic look;
        @(negedge clk_sys);
    endtask : look

    task automatic pins(input logic rn, input logic cs, input logic oe, input logic we);
        reset_n <= rn;
        chip_sel_n <= cs;
        out_en_n <= oe;
        write_n <= we;
    endtask : pins

    task automatic summarize;
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic t_reset;
        look;
        `CHK(dq_oe_n, 1'b1)
        `CHK(sync_mode, 1'b0)
        `CHK(wr_valid, 1'b0)
    endtask : t_reset

    task automatic t_async(input logic [ADDR_W-1:0] a);
        tick(1);
        pins(1'b1, 1'b0, 1'b0, 1'b1);
        address_latch_n <= 1'b0;
        addr <= a;
        tick(3);
        look;
        `CHK(dq_oe_n, 1'b0)
        `CHK(wait_oe_n, 1'b0)
        `CHK(wait_out, 1'b0)
        `CHK(dq_out, pat(a))
        `CHK(block_sel, a[ADDR_W-1:BLK_LSB])
        `CHK(array_addr, a)
        tick(1);
        address_latch_n <= 1'b1;
        addr <= ~a;
        tick(2);
        look;
        `CHK(array_addr, a)
    endtask : t_async

    task automatic t_float;
        for (int i = 0; i < 3; i++) begin
            tick(1);
            pins(1'b1, 1'b0, 1'b0, 1'b1);
            tick(2);
            look;
            `CHK(dq_oe_n, 1'b0)
            tick(1);
            if (i == 0)
                pins(1'b1, 1'b0, 1'b1, 1'b1);
            else if (i == 1)
                pins(1'b1, 1'b1, 1'b0, 1'b1);
            else
                pins(1'b0, 1'b0, 1'b0, 1'b1);
            tick(2);
            look;
            `CHK(dq_oe_n, 1'b1)
            `CHK(wait_oe_n, 1'b1)
        end
    endtask : t_float

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        tick(1);
        addr <= a;
        dq_in <= d;
        write_n <= 1'b0;
        tick(2);
        write_n <= 1'b1;
        tick(1);
        // Bus released after the strobe rise
        dq_in <= ~d;
    endtask : wr

    task automatic t_write;
        tick(1);
        pins(1'b1, 1'b0, 1'b1, 1'b1);
        address_latch_n <= 1'b0;
        hold_ready <= 1'b1;
        wr(23'h010002, 16'h1234);
        wr(23'h7F0004, 16'hBEEF);
        wr(23'h000006, 16'h5555);
        look;
        `CHK(buf_full, 1'b1)
        `CHK(wait_oe_n, 1'b1)
        `CHK(dq_oe_n, 1'b1)
        `CHK(wr_addr, 23'h010002)
        `CHK(wr_data, 16'h1234)
        tick(1);
        hold_ready <= 1'b0;
        tick(1);
        look;
        `CHK(wr_data, 16'hBEEF)
        `CHK(wr_addr, 23'h7F0004)
        tick(1);
        look;
        `CHK(wr_valid, 1'b0)
        tick(1);
        reset_n <= 1'b0;
        wr(23'h020000, 16'h0F0F);
        look;
        `CHK(wr_valid, 1'b0)
    endtask : t_write

    task automatic prot(input logic wp, input logic ld, input logic lk, input logic vpp, input logic vcc,
                        input logic rn, input logic unl, input logic ok);
        tick(1);
        write_protect_n <= wp;
        blk_lockdown <= ld;
        blk_locked <= lk;
        program_lockout_level <= vpp;
        core_lockout_level <= vcc;
        reset_n <= rn;
        unlock_req <= unl;
        modify_req <= !unl;
        tick(1);
        unlock_req <= 1'b0;
        modify_req <= 1'b0;
        look;
        `CHK(lockdown_active, !wp)
        `CHK(unl ? unlock_grant : modify_grant, ok)
        `CHK(unl ? unlock_reject : modify_refuse, !ok)
        tick(1);
        look;
        `CHK(unlock_grant | unlock_reject | modify_grant | modify_refuse, 1'b0)
    endtask : prot

    task automatic t_sync;
        tick(1);
        read_config <= 16'h0400;
        config_load <= 1'b1;
        pins(1'b1, 1'b0, 1'b0, 1'b1);
        address_latch_n <= 1'b0;
        addr <= 23'h345678;
        data_late <= 1'b1;
        tick(1);
        config_load <= 1'b0;
        tick(2);
        flash_clk <= 1'b1;
        tick(1);
        // Address moves after the first clock rise; the latch must ignore it
        addr <= 23'h0ABCDE;
        flash_clk <= 1'b0;
        tick(1);
        flash_clk <= 1'b1;
        tick(1);
        flash_clk <= 1'b0;
        look;
        `CHK(sync_mode, 1'b1)
        `CHK(array_addr, 23'h345678)
        `CHK(wait_oe_n, 1'b0)
        `CHK(wait_out, 1'b1)
        tick(1);
        data_late <= 1'b0;
        flash_clk <= 1'b1;
        tick(2);
        look;
        `CHK(wait_out, 1'b0)
        `CHK(dq_out, pat(23'h345678))
        tick(1);
        reset_n <= 1'b0;
        tick(2);
        look;
        `CHK(sync_mode, 1'b0)
        `CHK(wait_oe_n, 1'b1)
    endtask : t_sync

    initial begin
        sys_rst = 1'b1;
        pins(1'b1, 1'b1, 1'b1, 1'b1);
        address_latch_n = 1'b1;
        flash_clk = 1'b0;
        addr = 23'h000000;
        dq_in = 16'h0000;
        read_config = 16'h8000;
        config_load = 1'b0;
        write_protect_n = 1'b1;
        program_lockout_level = 1'b0;
        core_lockout_level = 1'b0;
        blk_lockdown = 1'b0;
        blk_locked = 1'b0;
        unlock_req = 1'b0;
        modify_req = 1'b0;
        hold_ready = 1'b0;
        data_late = 1'b0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_async(23'h012345);
        t_async(23'h7FFFFF);
        t_float;
        t_write;
        prot(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        prot(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        prot(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        prot(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        prot(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        prot(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        prot(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        prot(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        t_sync;
        summarize;
    end

    // Whole run needs about 95 cycles; 600 leaves ample margin
    initial begin
        #(600 * 100);
        num_errors++;
        summarize;
    end
endmodule : fbd_top_tb
